// ===== hw/scp_device.sv
`timescale 1ns/100ps
module scp_device
  import scp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  scp_bus_if.device       bus,
  input  wire logic       managementEnableStrap,
  input  wire logic [3:0] addrSelect,
  input  wire logic       loadDone,
  input  wire logic       channelSleepPin,
  input  wire logic [7:0] settingsCheckRef,
  output logic      [7:0] laneSleep,
  output logic            settingsApply,
  output logic            busIdle
);
  import scp_pkg::*;

  typedef enum logic [2:0] {
    SCP_IDLE = 3'b000, SCP_ADDR = 3'b001, SCP_AACK = 3'b011, SCP_RX = 3'b010,
    SCP_RACK = 3'b110, SCP_TX = 3'b111, SCP_TACK = 3'b101
  } scp_state_e;

  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] strapSync;
  logic [1:0] sleepPinSync;
  logic [7:0] rdSel;
  logic [3:0] selSync0;
  logic [3:0] selSync1;
  logic       sclD;
  logic       sdaD;
  scp_state_e state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bitCnt_reg;
  logic       isIndex_reg;
  logic [7:0] index_reg;
  logic [7:0] txByte_reg;
  logic       sdaOe_reg;
  logic [7:0] obsRw_reg;
  logic [7:0] laneSleep_reg;
  logic [7:0] pinBlock_reg;
  logic [7:0] checkByte_reg;
  logic [7:0] slaveCtrl_reg;
  logic [15:0] idleCnt_reg;
  logic       idle_reg;
  logic       afterStop_reg;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       addrMatch;
  logic       writeStrobe;
  logic [7:0] wrData;

  // Register read decode, used for the read path
  function automatic logic [7:0] readReg(input logic [7:0] idx);
    case (idx)
      REG_OBS_STATUS: readReg = (obsRw_reg & OBS_RW_MASK)
                              | {1'b0, selSync1, loadDone, 2'b00};
      REG_LANE_SLEEP: readReg = laneSleep_reg;
      REG_PIN_BLOCK:  readReg = pinBlock_reg;
      REG_CHECK_BYTE: readReg = checkByte_reg;
      REG_SLAVE_CTRL: readReg = slaveCtrl_reg;
      default:        readReg = 8'h00;
    endcase
  endfunction

  // Two-flop synchronisers for pins
  always_ff @(posedge clk) begin
    sclSync   <= {sclSync[0], bus.scl};
    sdaSync   <= {sdaSync[0], bus.sda};
    strapSync <= {strapSync[0], managementEnableStrap};
    sleepPinSync <= {sleepPinSync[0], channelSleepPin};
    selSync0  <= addrSelect;
    selSync1  <= selSync0;
    sclD      <= sclSync[1];
    sdaD      <= sdaSync[1];
  end

  assign sclRise   = sclSync[1] & ~sclD;
  assign sclFall   = ~sclSync[1] & sclD;
  assign startCond = sclSync[1] & sclD & sdaD & ~sdaSync[1];
  assign stopCond  = sclSync[1] & sclD & ~sdaD & sdaSync[1];
  // Address byte B0 + 2*code, direction bit ignored for compare
  assign addrMatch = shift_reg[7:1] == 7'(({1'b0, ADDR_BASE_BYTE}
                     + {4'h0, selSync1, 1'b0}) >> 1);
  assign wrData    = {shift_reg[6:0], sdaSync[1]};
  // Data byte commits on the ack slot it is being acknowledged in
  assign writeStrobe = (state_reg == SCP_RACK) & sclRise & ~isIndex_reg;

  // Byte for the read path; a process so that register updates are seen too
  always_comb rdSel = readReg(index_reg);

  // Bus-free and max-high idle timer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idleCnt_reg   <= 16'h0000;
      idle_reg      <= 1'b1;
      afterStop_reg <= 1'b0;
    end else if (!(sclSync[1] & sdaSync[1]) || startCond) begin
      idleCnt_reg <= 16'h0000;
      idle_reg    <= 1'b0;
      afterStop_reg <= 1'b0;
    end else begin
      if (stopCond) afterStop_reg <= 1'b1;
      if (idleCnt_reg != 16'hFFFF) idleCnt_reg <= idleCnt_reg + 16'h0001;
      if ((afterStop_reg && idleCnt_reg >= 16'(BUF_CYC))
          || idleCnt_reg >= 16'(HIGH_MAX_CYC)) begin
        idle_reg <= 1'b1;
      end
    end
  end

  // Slave protocol engine; data changes only while SCL low
  always_ff @(posedge clk) begin
    if (!resetn || !strapSync[1]) begin
      state_reg   <= SCP_IDLE;
      bitCnt_reg  <= 3'h0;
      shift_reg   <= 8'h00;
      isIndex_reg <= 1'b0;
      index_reg   <= 8'h00;
      txByte_reg  <= 8'h00;
      sdaOe_reg   <= 1'b0;
    end else if (startCond) begin
      state_reg  <= SCP_ADDR;
      bitCnt_reg <= 3'h0;
      shift_reg  <= 8'h00; // Stale byte must not be matched at the start's own clock fall
      sdaOe_reg  <= 1'b0;
    end else if (stopCond) begin
      state_reg <= SCP_IDLE;
      sdaOe_reg <= 1'b0;
    end else begin
      case (state_reg)
        SCP_IDLE: sdaOe_reg <= 1'b0;
        SCP_ADDR, SCP_RX: begin
          if (sclRise) begin
            shift_reg  <= wrData;
            bitCnt_reg <= bitCnt_reg + 3'h1;
          end
          if (sclFall && bitCnt_reg == 3'h0 && state_reg == SCP_ADDR
              && shift_reg != 8'h00) begin
            if (addrMatch) begin
              state_reg <= SCP_AACK;
              sdaOe_reg <= 1'b1;
            end else begin
              state_reg <= SCP_IDLE;
            end
          end else if (sclFall && bitCnt_reg == 3'h0 && state_reg == SCP_RX) begin
            state_reg <= SCP_RACK;
            sdaOe_reg <= 1'b1;
          end
        end
        SCP_AACK: begin
          if (sclFall) begin
            if (shift_reg[0]) begin
              state_reg  <= SCP_TX;
              txByte_reg <= {rdSel[6:0], 1'b0};
              sdaOe_reg  <= ~rdSel[7];
            end else begin
              state_reg   <= SCP_RX;
              isIndex_reg <= 1'b1;
              sdaOe_reg   <= 1'b0;
            end
            bitCnt_reg <= 3'h0;
            shift_reg  <= 8'h00;
          end
        end
        SCP_RACK: begin
          if (sclRise && isIndex_reg) index_reg <= shift_reg;
          if (sclFall) begin
            state_reg   <= SCP_RX;
            isIndex_reg <= 1'b0;
            sdaOe_reg   <= 1'b0;
          end
        end
        SCP_TX: begin
          if (sclFall) begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'h7) begin
              state_reg <= SCP_TACK;
              sdaOe_reg <= 1'b0;
            end else begin
              sdaOe_reg  <= ~txByte_reg[7];
              txByte_reg <= {txByte_reg[6:0], 1'b0};
            end
          end
        end
        SCP_TACK: begin
          if (sclRise) state_reg <= SCP_IDLE;
        end
        default: state_reg <= SCP_IDLE;
      endcase
    end
  end

  // Register file; read-only fields are not stored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      obsRw_reg     <= RST_OBS_RW;
      laneSleep_reg <= RST_LANE_SLEEP;
      pinBlock_reg  <= RST_PIN_BLOCK;
      checkByte_reg <= RST_CHECK_BYTE;
      slaveCtrl_reg <= RST_SLAVE_CTRL;
    end else if (writeStrobe) begin
      case (index_reg)
        REG_OBS_STATUS: obsRw_reg     <= shift_reg & OBS_RW_MASK;
        REG_LANE_SLEEP: laneSleep_reg <= shift_reg;
        REG_PIN_BLOCK:  pinBlock_reg  <= shift_reg;
        REG_CHECK_BYTE: checkByte_reg <= shift_reg;
        REG_SLAVE_CTRL: slaveCtrl_reg <= shift_reg;
        default: ;
      endcase
    end
  end

  // Pin applies only when not blocked; register bits always win when set
  always_ff @(posedge clk) begin
    if (!resetn) begin
      laneSleep     <= 8'h00;
      settingsApply <= 1'b0;
    end else begin
      laneSleep <= laneSleep_reg
                 | {8{sleepPinSync[1] & ~pinBlock_reg[BLOCK_BIT]}};
      settingsApply <= slaveCtrl_reg[CTRL_NO_CHECK]
                     | (checkByte_reg == settingsCheckRef);
    end
  end

  assign busIdle      = idle_reg;
  assign bus.devSdaOe = sdaOe_reg;
endmodule

// ===== hw/scp_pkg.sv
package scp_pkg;
  // Register indices
  localparam logic [7:0] REG_OBS_STATUS   = 8'h00;
  localparam logic [7:0] REG_LANE_SLEEP   = 8'h01;
  localparam logic [7:0] REG_PIN_BLOCK    = 8'h02;
  localparam logic [7:0] REG_CHECK_BYTE   = 8'h05;
  localparam logic [7:0] REG_SLAVE_CTRL   = 8'h06;
  // Reset values
  localparam logic [7:0] RST_LANE_SLEEP   = 8'h00;
  localparam logic [7:0] RST_PIN_BLOCK    = 8'h00;
  localparam logic [7:0] RST_CHECK_BYTE   = 8'h00;
  localparam logic [7:0] RST_SLAVE_CTRL   = 8'h10;
  localparam logic [7:0] RST_OBS_RW       = 8'h00;
  // Field positions
  localparam int OBS_ADDR_LSB     = 3;
  localparam int OBS_LOAD_DONE    = 2;
  localparam int CTRL_NO_CHECK    = 3;
  localparam int BLOCK_BIT        = 0;
  localparam logic [7:0] OBS_RW_MASK = 8'h83;
  // Slave address: byte is base plus twice the select code
  localparam logic [7:0] ADDR_BASE_BYTE   = 8'hB0;
  // Timing, clk 200 MHz
  localparam int CLK_MHZ          = 200;
  localparam int T_BUF_NS         = 4700;
  localparam int T_HIGH_MAX_NS    = 50000;
  localparam int BUF_CYC          = (T_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_MAX_CYC     = (T_HIGH_MAX_NS * CLK_MHZ) / 1000;
  // Host bit timing: one quarter of a bus clock period, in clk cycles
  localparam int QTR_CYC          = 6;
  // Host command register map (APB byte addresses)
  localparam logic [7:0] APB_CMD        = 8'h00;
  localparam logic [7:0] APB_STATUS     = 8'h04;
  localparam int CMD_GO           = 0;
  localparam int CMD_READ         = 1;
  localparam int ST_BUSY          = 0;
  localparam int ST_NACK          = 1;
endpackage

// ===== hw/scp_bus_if.sv
`timescale 1ns/100ps
// Two-wire bus; each end drives a line low when its enable is high
interface scp_bus_if;
  logic devSdaOe;
  logic hostSdaOe;
  logic hostSclOe;
  logic sda;
  logic scl;
  assign sda = ~(devSdaOe | hostSdaOe);
  assign scl = ~hostSclOe;
  modport device (input sda, input scl, output devSdaOe);
  modport host (input sda, input scl, output hostSdaOe, output hostSclOe);
endinterface

// ===== hw/scp_host.sv
`timescale 1ns/100ps
module scp_host
  import scp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  scp_bus_if.host          bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import scp_pkg::*;

  // Command word: [1] read, [0] go, [15:8] index, [23:16] data, [31:25] address
  logic [31:0] cmd_reg;
  logic        busy_reg;
  logic        nack_reg;
  logic [7:0]  rdData_reg;
  logic [1:0]  sdaSync;
  logic [3:0]  qCnt_reg;
  logic [1:0]  phase_reg;
  logic [5:0]  step_reg;
  logic [3:0]  bitIx_reg;
  logic        sclOe_reg;
  logic        sdaOe_reg;
  logic        tick;
  logic        apbWr;
  logic [7:0]  curByte;

  // Byte to send for each step
  function automatic logic [7:0] byteOut(input logic [5:0] s);
    case (s)
      6'h01:   byteOut = {cmd_reg[31:25], 1'b0};
      6'h02:   byteOut = cmd_reg[15:8];
      6'h03:   byteOut = cmd_reg[23:16];
      6'h05:   byteOut = {cmd_reg[31:25], 1'b1};
      default: byteOut = 8'hFF;
    endcase
  endfunction

  // Current byte, held in a variable since a call result cannot be bit-selected
  always_comb curByte = byteOut(step_reg);

  assign tick  = qCnt_reg == 4'(QTR_CYC - 1);
  assign apbWr = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk) sdaSync <= {sdaSync[0], bus.sda};

  // APB slave: zero wait states
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        APB_CMD:    prdata <= cmd_reg;
        APB_STATUS: prdata <= {16'h0000, rdData_reg, 6'h00, nack_reg, busy_reg};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  // Quarter-bit divider for the bus clock
  always_ff @(posedge clk) begin
    if (!resetn || !busy_reg) qCnt_reg <= 4'h0;
    else if (tick) qCnt_reg <= 4'h0;
    else qCnt_reg <= qCnt_reg + 4'h1;
  end

  // Bit sequencer: steps are start, bytes with ack, restart, stop.
  // step 0 start, 1..3 address/index/data bytes, 4 restart, 5 read addr, 6 read byte, 7 stop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_reg    <= 32'h00000000;
      busy_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      rdData_reg <= 8'h00;
      phase_reg  <= 2'h0;
      step_reg   <= 6'h00;
      bitIx_reg  <= 4'h0;
      sclOe_reg  <= 1'b0;
      sdaOe_reg  <= 1'b0;
    end else if (!busy_reg) begin
      if (apbWr && paddr == APB_CMD && pwdata[CMD_GO]) begin
        cmd_reg   <= pwdata;
        busy_reg  <= 1'b1;
        nack_reg  <= 1'b0;
        step_reg  <= 6'h00;
        phase_reg <= 2'h0;
        bitIx_reg <= 4'h0;
      end
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      case (step_reg)
        6'h00, 6'h04: begin // Start while SCL high
          case (phase_reg)
            2'h0: sdaOe_reg <= 1'b0;
            2'h1: sclOe_reg <= 1'b0;
            2'h2: sdaOe_reg <= 1'b1;
            default: begin
              sclOe_reg <= 1'b1;
              step_reg  <= step_reg + 6'h01;
              bitIx_reg <= 4'h0;
            end
          endcase
        end
        6'h07: begin // Stop
          case (phase_reg)
            2'h0: sdaOe_reg <= 1'b1;
            2'h1: sclOe_reg <= 1'b0;
            2'h2: sdaOe_reg <= 1'b0;
            default: busy_reg <= 1'b0;
          endcase
        end
        default: begin // Byte plus ack slot, data set while SCL low
          case (phase_reg)
            2'h0: begin
              if (bitIx_reg == 4'h8)
                sdaOe_reg <= 1'b0; // Ack slot released; after a read byte it is the nack
              else if (step_reg == 6'h06)
                sdaOe_reg <= 1'b0;
              else
                sdaOe_reg <= ~curByte[3'(7 - bitIx_reg)];
            end
            2'h1: sclOe_reg <= 1'b0;
            2'h2: begin
              if (bitIx_reg == 4'h8 && step_reg != 6'h06 && sdaSync[1])
                nack_reg <= 1'b1;
              if (step_reg == 6'h06 && bitIx_reg != 4'h8)
                rdData_reg <= {rdData_reg[6:0], sdaSync[1]};
            end
            default: begin
              sclOe_reg <= 1'b1;
              if (bitIx_reg != 4'h8) begin
                bitIx_reg <= bitIx_reg + 4'h1;
              end else begin
                bitIx_reg <= 4'h0;
                if (nack_reg || step_reg == 6'h06) step_reg <= 6'h07;
                else if (step_reg == 6'h03) step_reg <= 6'h07;
                else if (step_reg == 6'h02 && cmd_reg[CMD_READ]) step_reg <= 6'h04;
                else step_reg <= step_reg + 6'h01;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign bus.hostSclOe = sclOe_reg;
  assign bus.hostSdaOe = sdaOe_reg;
endmodule

// ===== bench/scp_properties.sv
`timescale 1ns/100ps
// Link checker, sees the shared two-wire signals and each end's drive enables
module scp_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic devSdaOe,
  input wire logic hostSdaOe,
  input wire logic hostSclOe,
  input wire logic sda,
  input wire logic scl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Frame markers: data edges while the clock line stays high
  sequence sStart;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence sStop;
    scl && $past(scl) && $rose(sda);
  endsequence
  // Device must leave the data line alone right after a marker
  sequence sDevQuiet;
    !devSdaOe [*8];
  endsequence

  chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("device data changed while clock high");
  chk_dev_hold_fall: assert property ($fell(scl) |-> $stable(devSdaOe) [*2])
    else $error("device data changed too soon after clock fall");
  chk_ack_on_low: assert property ($rose(devSdaOe) |-> !scl)
    else $error("device pulled data low while clock high");
  chk_ack_off_low: assert property ($fell(devSdaOe) |-> !scl)
    else $error("device released data while clock high");
  chk_ack_clocked: assert property ($rose(devSdaOe) |-> ##[1:24] $rose(scl))
    else $error("device drive not clocked by host");
  chk_start_quiet: assert property (sStart |-> ##1 sDevQuiet)
    else $error("device drove data after start");
  chk_stop_quiet: assert property (sStop |-> ##1 sDevQuiet)
    else $error("device drove data after stop");
  chk_scl_high_len: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_host_edge_apart: assert property ($changed(hostSclOe) |-> $stable(hostSdaOe))
    else $error("host moved data and clock together");

  // Main link events seen at least once
  cov_start: cover property (sStart);
  cov_stop: cover property (sStop);
endmodule

// ===== bench/smbus_slave_config_port_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module smbus_slave_config_port_bench;
  import scp_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        managementEnableStrap = 1'b1;
  logic [3:0]  addrSelect = 4'h0;
  logic        loadDone = 1'b0;
  logic        channelSleepPin = 1'b0;
  logic [7:0]  settingsCheckRef = 8'h5A;
  logic [7:0]  laneSleep;
  logic        settingsApply;
  logic        busIdle;
  logic [6:0]  devAddr;
  logic [7:0]  rdv;
  logic        nk;
  int          miscompares = 0;
  int          cmpCount = 0;

  scp_bus_if busLink ();
  scp_device scp_device_i (.clk(clk), .resetn(resetn), .bus(busLink),
    .managementEnableStrap(managementEnableStrap), .addrSelect(addrSelect),
    .loadDone(loadDone), .channelSleepPin(channelSleepPin),
    .settingsCheckRef(settingsCheckRef), .laneSleep(laneSleep),
    .settingsApply(settingsApply), .busIdle(busIdle));
  scp_host scp_host_i (.clk(clk), .resetn(resetn), .bus(busLink), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  scp_properties scp_properties_i (.clk(clk), .resetn(resetn),
    .devSdaOe(busLink.devSdaOe), .hostSdaOe(busLink.hostSdaOe),
    .hostSclOe(busLink.hostSclOe), .sda(busLink.sda), .scl(busLink.scl));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // One APB transfer; request held until pready is seen at an edge
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    `CHK("slave error", 1'b0, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Whole bus transaction: command, then poll status until the host is free
  task automatic smb(input logic rdOp, input logic [6:0] a7, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd, output logic nack);
    logic [31:0] st;
    apbXfer(1'b1, APB_CMD, {a7, 1'b0, wd, idx, 6'h00, rdOp, 1'b1}, st);
    st = 32'h00000001;
    while (st[ST_BUSY] !== 1'b0) apbXfer(1'b0, APB_STATUS, 32'h00000000, st);
    rd = st[15:8];
    nack = st[ST_NACK];
  endtask

  task automatic regWr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] r;
    logic       n;
    smb(1'b0, devAddr, idx, v, r, n);
    `CHK("write ack", 1'b0, n)
  endtask

  task automatic regRd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] r;
    logic       n;
    smb(1'b1, devAddr, idx, 8'h00, r, n);
    `CHK("read ack", 1'b0, n)
    `CHK("read data", e, r)
  endtask

  // Pin level and block bit against the stored per-lane bits
  task automatic sleepCase(input logic pin, input logic [7:0] blk, input logic [7:0] v,
                           input logic [7:0] e);
    @(posedge clk);
    channelSleepPin <= pin;
    regWr(REG_PIN_BLOCK, blk);
    regWr(REG_LANE_SLEEP, v);
    `CHK("lane sleep", e, laneSleep)
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("idle after reset", 1'b1, busIdle)
    `CHK("apply after reset", 1'b0, settingsApply)
    devAddr = 7'h58;
    regRd(REG_LANE_SLEEP, 8'h00);
    regRd(REG_PIN_BLOCK, 8'h00);
    regRd(REG_CHECK_BYTE, 8'h00);
    regRd(REG_SLAVE_CTRL, 8'h10);
    `CHK("busy after stop", 1'b0, busIdle)
    repeat (1000) @(posedge clk);
    `CHK("bus free", 1'b1, busIdle)
    // Every select code; a neighbour's address must be ignored
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      addrSelect <= 4'(k);
      loadDone <= k[0];
      devAddr = 7'((8'hB0 + 8'(2 * k)) >> 1);
      regRd(REG_OBS_STATUS, {1'b0, 4'(k), k[0], 2'b00});
      smb(1'b0, devAddr + 7'h01, REG_LANE_SLEEP, 8'hFF, rdv, nk);
      `CHK("foreign address", 1'b1, nk)
    end
    `CHK("ignored write", 8'h00, laneSleep)
    regWr(REG_OBS_STATUS, 8'h81);
    regRd(REG_OBS_STATUS, 8'hFD);
    sleepCase(1'b1, 8'h00, 8'h00, 8'hFF);
    sleepCase(1'b1, 8'h01, 8'h00, 8'h00);
    sleepCase(1'b1, 8'h01, 8'hA5, 8'hA5);
    sleepCase(1'b0, 8'h00, 8'hFF, 8'hFF);
    regWr(REG_CHECK_BYTE, 8'h5A);
    `CHK("check match", 1'b1, settingsApply)
    regWr(REG_CHECK_BYTE, 8'h5B);
    `CHK("check mismatch", 1'b0, settingsApply)
    regWr(REG_SLAVE_CTRL, 8'h18);
    `CHK("check bypass", 1'b1, settingsApply)
    regRd(REG_SLAVE_CTRL, 8'h18);
    // Slave must stay silent with the strap low
    @(posedge clk);
    managementEnableStrap <= 1'b0;
    smb(1'b0, devAddr, REG_LANE_SLEEP, 8'h33, rdv, nk);
    `CHK("strap low", 1'b1, nk)
    @(posedge clk);
    managementEnableStrap <= 1'b1;
    regRd(REG_LANE_SLEEP, 8'hFF);
    finishTest();
  end

  // Watchdog, about twice the expected run, kept under the cycle budget
  initial begin
    #400000;
    miscompares++;
    $display("watchdog expired");
    finishTest();
  end
endmodule
